// >>> core/telemetry_readback_registers.v
// Telemetry read-back register bank of a digital power-supply controller.
// Assumes the serial-bus front end issues single-cycle byte read and write strobes with an
// offset, and that converter samples arrive synchronous to CLK.
// How it works
// (R1) Power read MSB then LSB, consecutive reads.
// (R2) Power is the upper 16 of the 24 bits of remote voltage times output current.
// (R3) Temperature twelve bits in 15:4, two reads.
// (R4) Temperature code linear in thermistor voltage.
// (R5) Share level reads zero when sharing master.
// (R6) Modulation amount reported as eight bits.
// (R7) Impedance is voltage difference over current.
// (R8) Trim bit 7 selects negative gain.
// (R9) Trim bits 6:0 set gain magnitude.
// (R10) Writes to read-only registers are ignored.
`timescale 1ns/10ps
`default_nettype none
`include "telemetry_consts.vh"
module telemetry_readback_registers (
  // Clock, reset, enable
  input wire CLK,
  input wire ARST_N,
  input wire CE,
  // Byte register access
  input wire RD_STB,
  input wire WR_STB,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  output reg [7:0] RDATA,
  output reg RVALID,
  // Converter samples
  input wire [11:0] REMOTE_SENSE_VOLTAGE,
  input wire [11:0] LOCAL_SENSE_VOLTAGE,
  input wire [11:0] OUTPUT_CURRENT_SENSE,
  input wire [11:0] THERMISTOR_INPUT,
  input wire SAMPLE_VALID,
  input wire [7:0] SHARE_LEVEL,
  input wire SHARE_MASTER,
  input wire [7:0] MODULATION_AMOUNT,
  // Trim outputs
  output reg GAIN_NEGATIVE,
  output reg [6:0] GAIN_MAGNITUDE
);
  reg [15:0] power_r;
  reg [11:0] temp_r;
  reg [7:0] share_r;
  reg [7:0] mod_r;
  reg [7:0] imped_r;
  reg [7:0] trim_r;
  reg [7:0] low_hold_r;
  reg second_r;
  reg [7:0] last_addr_r;
  reg [7:0] rdata_nxt;
  reg [23:0] prod;
  reg [11:0] vdiff;
  wire div_busy;
  wire div_done;
  wire [7:0] div_q;
  reg [15:0] power_nxt;
  reg [11:0] temp_nxt;
  reg [7:0] share_nxt;
  reg [7:0] mod_nxt;
  reg [7:0] imped_nxt;
  reg [7:0] trim_nxt;
  reg [7:0] low_hold_nxt;
  reg second_nxt;
  reg [7:0] last_addr_nxt;
  reg div_start_r;
  reg [11:0] dividend_r;
  reg [11:0] divisor_r;

  always @* begin
    prod = REMOTE_SENSE_VOLTAGE * OUTPUT_CURRENT_SENSE;
    // A negative drop means the remote point reads higher; treat as zero impedance.
    if (LOCAL_SENSE_VOLTAGE > REMOTE_SENSE_VOLTAGE)
      vdiff = LOCAL_SENSE_VOLTAGE - REMOTE_SENSE_VOLTAGE;
    else
      vdiff = 12'h000;
  end

  // The divider needs its operands for twelve cycles, longer than the converter holds
  // its samples, so they are captured with the sample strobe and the division starts
  // one edge later. A sample that arrives mid-division leaves the impedance unchanged.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_start_r <= 1'b0;
      dividend_r <= 12'h000;
      divisor_r <= 12'h000;
    end else if (CE) begin
      div_start_r <= SAMPLE_VALID && !div_busy && !div_start_r;
      if (SAMPLE_VALID && !div_busy && !div_start_r) begin
        dividend_r <= vdiff;
        divisor_r <= OUTPUT_CURRENT_SENSE;
      end
    end
  end

  line_impedance_div u_div (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .start(div_start_r),
    .dividend(dividend_r),
    .divisor(divisor_r),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_q)
  ); // R7

  // Next values of the bank. Thermistor and modulation samples pass straight through because the converter
  // transfer is already linear; the impedance follows fourteen cycles behind them.
  always @* begin
    power_nxt = power_r;
    temp_nxt = temp_r;
    share_nxt = share_r;
    mod_nxt = mod_r;
    imped_nxt = imped_r;
    if (SAMPLE_VALID) begin
      power_nxt = prod[23:8]; // R2
      temp_nxt = THERMISTOR_INPUT; // R4
      share_nxt = SHARE_MASTER ? 8'h00 : SHARE_LEVEL; // R5
      mod_nxt = MODULATION_AMOUNT; // R6
    end
    if (div_done) begin
      imped_nxt = div_q; // R7
    end
  end

  // Only the trim offset decodes writes, so the read-only registers never change
  // from the bus side.
  always @* begin
    trim_nxt = trim_r;
    if (WR_STB && ADDR == `OFS_TRIM) begin
      trim_nxt = WDATA; // R10
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      power_r <= 16'h0000;
      temp_r <= 12'h000;
      share_r <= 8'h00;
      mod_r <= 8'h00;
      imped_r <= 8'h00;
    end else if (CE) begin
      power_r <= power_nxt;
      temp_r <= temp_nxt;
      share_r <= share_nxt;
      mod_r <= mod_nxt;
      imped_r <= imped_nxt;
    end
  end

  // The trim outputs follow the register one cycle later, so a write reaches the
  // current-sense path on the second edge after its strobe.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      trim_r <= `TRIM_RESET;
      GAIN_NEGATIVE <= 1'b0;
      GAIN_MAGNITUDE <= 7'h00;
    end else if (CE) begin
      trim_r <= trim_nxt;
      GAIN_NEGATIVE <= trim_r[`TRIM_POL_BIT]; // R8
      GAIN_MAGNITUDE <= trim_r[`TRIM_MAG_MSB:0]; // R9
    end
  end

  // The low byte is captured with the first read, so both halves come from one sample.
  always @* begin
    rdata_nxt = `READ_DATA_RESET;
    case (ADDR)
      `OFS_POWER: rdata_nxt = (second_r && last_addr_r == `OFS_POWER) ? low_hold_r
                              : power_r[15:8]; // R1
      `OFS_TEMP: rdata_nxt = (second_r && last_addr_r == `OFS_TEMP) ? low_hold_r
                             : temp_r[11:4]; // R3
      `OFS_SHARE: rdata_nxt = SHARE_MASTER ? 8'h00 : share_r; // R5
      `OFS_MOD: rdata_nxt = mod_r;
      `OFS_IMPED: rdata_nxt = imped_r;
      `OFS_TRIM: rdata_nxt = trim_r;
      default: rdata_nxt = `READ_DATA_RESET;
    endcase
  end

  // A read of a wide register opens a pair and latches its low byte; the next read of
  // the same offset closes it. Any other access breaks the pair.
  always @* begin
    second_nxt = second_r;
    low_hold_nxt = low_hold_r;
    last_addr_nxt = last_addr_r;
    if (RD_STB) begin
      last_addr_nxt = ADDR;
      if (!(second_r && last_addr_r == ADDR) &&
          (ADDR == `OFS_POWER || ADDR == `OFS_TEMP)) begin
        second_nxt = 1'b1;
        if (ADDR == `OFS_POWER) begin
          low_hold_nxt = power_r[7:0]; // R1
        end else begin
          low_hold_nxt = {temp_r[3:0], 4'h0}; // R3
        end
      end else begin
        second_nxt = 1'b0;
      end
    end else if (WR_STB) begin
      second_nxt = 1'b0;
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= `READ_DATA_RESET;
      RVALID <= 1'b0;
      low_hold_r <= 8'h00;
      second_r <= 1'b0;
      last_addr_r <= 8'h00;
    end else if (CE) begin
      RVALID <= RD_STB;
      if (RD_STB) begin
        RDATA <= rdata_nxt;
      end
      low_hold_r <= low_hold_nxt;
      second_r <= second_nxt;
      last_addr_r <= last_addr_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> common/telemetry_consts.vh
// Register offsets, field positions, reset values and scaling constants of the telemetry bank.
// Included by the register bank; holds definitions only.
`ifndef TELEMETRY_CONSTS_VH
`define TELEMETRY_CONSTS_VH
`define OFS_POWER 8'h19
`define OFS_TEMP 8'h1a
`define OFS_SHARE 8'h1d
`define OFS_MOD 8'h1e
`define OFS_IMPED 8'h1f
`define OFS_TRIM 8'h21
`define TRIM_POL_BIT 7
`define TRIM_MAG_MSB 6
`define TRIM_RESET 8'h00
`define TEMP_FULL_CODE 12'hf7c
`define READ_DATA_RESET 8'h00
`endif

// >>> core/line_impedance_div.v
// Sequential restoring divider producing the 8-bit line impedance quotient.
// Assumes the caller holds the operands stable while busy is high.
`timescale 1ns/10ps
`default_nettype none
module line_impedance_div (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire start,
  input wire [11:0] dividend,
  input wire [11:0] divisor,
  output reg busy,
  output reg done,
  output reg [7:0] quotient
);
  reg [3:0] cnt_r;
  reg [11:0] rem_r;
  reg [11:0] quo_r;
  wire [12:0] trial;
  assign trial = {rem_r, quo_r[11]} - {1'b0, divisor};
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 4'h0;
      rem_r <= 12'h000;
      quo_r <= 12'h000;
      busy <= 1'b0;
      done <= 1'b0;
      quotient <= 8'h00;
    end else if (ce) begin
      done <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        cnt_r <= 4'h0;
        rem_r <= 12'h000;
        quo_r <= dividend;
      end else if (busy) begin
        if (!trial[12]) begin
          rem_r <= trial[11:0];
          quo_r <= {quo_r[10:0], 1'b1};
        end else begin
          rem_r <= {rem_r[10:0], quo_r[11]};
          quo_r <= {quo_r[10:0], 1'b0};
        end
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == 4'hb) begin
          busy <= 1'b0;
          done <= 1'b1;
          // Quotients beyond eight bits saturate; a zero divisor gives full scale.
          if (quo_r[10:7] != 4'h0)
            quotient <= 8'hff;
          else
            quotient <= {quo_r[6:0], ~trial[12]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/trr_host.sv
// Host model issuing byte reads and writes to the telemetry bank.
// Assumes the bench clock; signals change on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module trr_host (
  input wire logic CLK,
  input wire logic [7:0] RDATA,
  output logic RD_STB,
  output logic WR_STB,
  output logic [7:0] ADDR,
  output logic [7:0] WDATA
);
  initial {RD_STB, WR_STB, ADDR, WDATA} = '0;
  // Released lines show the inverse so a stale value is never mistaken for a fresh one.
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge CLK) {RD_STB, WR_STB, ADDR, WDATA} = {!w, w, a, d};
    @(negedge CLK) q = RDATA;
    {RD_STB, WR_STB, ADDR, WDATA} = {2'b00, ~a, ~d};
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    acc(0, a, 0, v[15:8]);
    acc(0, a, 0, v[7:0]);
  endtask
endmodule
`default_nettype wire

// >>> dv/trr_asserts.sv
// Checker on the bank's register port and trim outputs.
// Assumes CE is held high.
`timescale 1ns/10ps
`default_nettype none
module trr_asserts (
  input wire logic CLK, ARST_N, RD_STB, WR_STB, RVALID, SHARE_MASTER, GAIN_NEGATIVE,
  input wire logic [7:0] ADDR, WDATA, RDATA, MODULATION_AMOUNT,
  input wire logic [6:0] GAIN_MAGNITUDE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire logic [7:0] trim = {GAIN_NEGATIVE, GAIN_MAGNITUDE};
  a_read_answer: assert property (RD_STB |=> RVALID) else $error("no answer");
  a_answer_cause: assert property (RVALID |-> $past(RD_STB)) else $error("stray answer");
  a_rdata_hold: assert property (!RD_STB |=> $stable(RDATA)) else $error("byte moved");
  a_trim_write: assert property (WR_STB && ADDR == 8'h21 |=> ##1 trim == $past(WDATA, 2))
    else $error("trim not written");
  a_trim_hold: assert property (!(WR_STB && ADDR == 8'h21) && !$past(WR_STB)
    |=> $stable(trim)) else $error("trim changed");
  a_trim_read: assert property (RD_STB && !WR_STB && !$past(WR_STB) && ADDR == 8'h21
    |=> RDATA == $past(trim))
    else $error("trim read wrong");
  a_share_master: assert property (SHARE_MASTER[*3] ##0 RD_STB && ADDR == 8'h1d |=> !RDATA)
    else $error("share not zero");
  a_mod_read: assert property ($stable(MODULATION_AMOUNT)[*3] ##0 RD_STB && ADDR == 8'h1e
    |=> RDATA == $past(MODULATION_AMOUNT)) else $error("modulation wrong");
  cover property (RD_STB && ADDR == 8'h19);
  cover property (RD_STB && ADDR == 8'h1a);
  cover property (WR_STB && ADDR == 8'h21);
endmodule
bind telemetry_readback_registers trr_asserts u_chk (.*);
`default_nettype wire

// >>> dv/tb_telemetry_readback_registers.sv
// Self-checking bench for the telemetry bank, driven through the host model.
// Assumes the bank, its header and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_telemetry_readback_registers;
  logic CLK = 0, ARST_N = 0, SV = 0, SM = 0, RD, WR;
  logic [11:0] rv = 0, lv = 0, oc = 0, th = 0;
  logic [7:0] sl = 0, md = 0, a, w, q, r, g;
  logic GN;
  logic [6:0] GM;
  logic [15:0] v;
  logic [31:0] s = 32'h36d9e668;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  always #2 CLK = ~CLK;
  trr_host u_host (.CLK(CLK), .RDATA(q), .RD_STB(RD), .WR_STB(WR), .ADDR(a), .WDATA(w));
  telemetry_readback_registers u_dut (.CLK(CLK), .ARST_N(ARST_N), .CE(1'b1), .RD_STB(RD),
    .WR_STB(WR), .ADDR(a), .WDATA(w), .RDATA(q), .RVALID(), .REMOTE_SENSE_VOLTAGE(rv),
    .LOCAL_SENSE_VOLTAGE(lv), .OUTPUT_CURRENT_SENSE(oc), .THERMISTOR_INPUT(th),
    .SAMPLE_VALID(SV), .SHARE_LEVEL(sl), .SHARE_MASTER(SM), .MODULATION_AMOUNT(md),
    .GAIN_NEGATIVE(GN), .GAIN_MAGNITUDE(GM));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Impedance saturates at full scale; a negative drop reads zero.
  function automatic logic [7:0] imp(input logic [11:0] l, rr, c);
    int d;
    d = (c == 0) ? 255 : (l <= rr) ? 0 : (l - rr) / c;
    return (d > 255) ? 8'hff : 8'(d);
  endfunction
  task automatic check(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge CLK) if (++cyc > 5000) begin
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (4) @(negedge CLK);
    ARST_N = 1;
    check({GN, GM}, 0);
    for (int i = 0; i < 6; i++) begin
      @(negedge CLK) {rv, oc} = (i == 0) ? 24'hfffffe : 24'(rnd());
      lv = rv + 12'(rnd() % 64);
      th = (i == 1) ? 12'hf7c : 12'(rnd());
      {sl, md} = 16'(rnd());
      SM = i[0];
      SV = 1;
      @(negedge CLK) SV = 0;
      repeat (20) @(negedge CLK);
      u_host.rd16(8'h19, v);
      check(v, 16'((rv * 24'(oc)) >> 8));
      u_host.rd16(8'h1a, v);
      check(v, {th, 4'h0});
      u_host.acc(0, 8'h1f, 0, r);
      check(r, imp(lv, rv, oc));
      u_host.acc(0, 8'h1d, 0, r);
      check(r, SM ? 8'h00 : sl);
      u_host.acc(0, 8'h1e, 0, r);
      check(r, md);
      g = (i == 2) ? 8'h80 : 8'(rnd());
      u_host.acc(1, 8'h21, g, r);
      @(negedge CLK);
      check({GN, GM}, g);
      u_host.acc(1, 8'h1e, ~g, r);
      u_host.acc(0, 8'h21, 0, r);
      check(r, g);
      $display("test %0d done", i);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
